// ### pafm_pkg.sv
// Package for the port alternate-function multiplexer.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
package pafm_pkg;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] PORT_OFS = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;
  // Control register bit positions
  localparam int EXT_BUS_MODE_BIT = 0;
  localparam int HOLD_EN_BIT = 1;
  localparam int READY_EN_BIT = 2;
  localparam int CLK_OUT_EN_BIT = 3;
  localparam int SER_OUT_EN_BIT = 4;
  localparam int SER_RUN_BIT = 5;
  localparam int OD_BIT0 = 8;
  localparam int OD_BIT1 = 9;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PORT_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NPIN = 5;
  localparam int DIR_LSB = 8;
  // Writable bits; the rest read back as zero
  localparam logic [31:0] CTRL_WMASK = 32'h0000_033f;
  localparam logic [31:0] PORT_WMASK = 32'h0000_1f1f;
  // Pins whose alternate function is an output: port3 bit5, port3 bit7, port4 bit1
  localparam logic [4:0] ALT_OUT_PINS = 5'h15;

  // One pin's drive: output level, output enable (low means driving)
  typedef struct packed {
    logic out;
    logic oe_n;
  } pafm_pin_t;
endpackage : pafm_pkg

// ### pafm_pin_cell.sv
// One port pin with optional open-drain drive.
// Assumes pin input is already synchronised by the caller.
`timescale 1ns/100ps
module pafm_pin_cell (
  input wire logic dout_i,
  input wire logic dir_out_i,
  input wire logic od_sel_i,
  output pafm_pkg::pafm_pin_t pin_o
);
  // Open drain only counts when the pin is an output
  wire logic od_active = dir_out_i & od_sel_i;
  assign pin_o.out = od_active ? 1'b0 : dout_i;
  assign pin_o.oe_n = ~dir_out_i | (od_active & dout_i);
endmodule : pafm_pin_cell

// ### pafm_mux.sv
// Port 3 bits 5..7 and port 4 bits 0..1 alternate-function multiplexer.
// Assumes AXI4-Lite master on ref_clk_i; pins are asynchronous and synchronised here.
`timescale 1ns/100ps
module pafm_mux (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic machine_clk_i,
  input wire logic hold_acknowledge_out_i,
  input wire logic serial_transmit_output_i,
  output logic bus_ready_o,
  output logic serial_receive_input_o,
  input wire logic [4:0] pin_in_i,
  output logic [4:0] pin_out_o,
  output logic [4:0] pin_oe_n_o
);
  // Pin index: 0=port3 bit5, 1=port3 bit6, 2=port3 bit7, 3=port4 bit0, 4=port4 bit1
  logic [31:0] ctrl_ff;
  logic [31:0] port_ff;
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic aw_got_ff, w_got_ff;
  logic aw_hi_bad_ff;
  logic [3:0] aw_ofs_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;

  wire logic ext_mode = ctrl_ff[pafm_pkg::EXT_BUS_MODE_BIT];
  wire logic hold_sel = ext_mode & ctrl_ff[pafm_pkg::HOLD_EN_BIT];
  wire logic ready_sel = ext_mode & ctrl_ff[pafm_pkg::READY_EN_BIT];
  wire logic clk_sel = ext_mode & ctrl_ff[pafm_pkg::CLK_OUT_EN_BIT];
  wire logic sout_sel = ctrl_ff[pafm_pkg::SER_OUT_EN_BIT];
  wire logic ser_run = ctrl_ff[pafm_pkg::SER_RUN_BIT];

  // Port register: data in bits 4:0, direction in bits 12:8 (1 = output)
  wire logic [4:0] gp_data = port_ff[pafm_pkg::NPIN-1:0];
  wire logic [4:0] gp_dir = port_ff[pafm_pkg::DIR_LSB +: pafm_pkg::NPIN];

  // Pins are asynchronous; two stages before use
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
    end else begin
      sync1_ff <= pin_in_i;
      // Only the second stage is read, so a metastable first stage never reaches logic
      sync2_ff <= sync1_ff;
    end
  end

  assign bus_ready_o = ready_sel ? sync2_ff[1] : 1'b1;
  assign serial_receive_input_o = ser_run ? sync2_ff[3] : 1'b1;

  // Hold, clock and serial-out alternate functions force the pin to output with the peripheral's level
  wire logic [4:0] alt_sel = {sout_sel, 1'b0, clk_sel, ready_sel, hold_sel};
  wire logic [4:0] alt_val = {serial_transmit_output_i, 1'b0, machine_clk_i, 1'b0, hold_acknowledge_out_i};
  // Ready pin is an input while selected, so its direction is cleared
  wire logic [4:0] eff_dir = (gp_dir | (alt_sel & pafm_pkg::ALT_OUT_PINS)) & ~{3'h0, ready_sel, 1'b0};
  wire logic [4:0] eff_dat = (alt_sel & alt_val) | (~alt_sel & gp_data);
  wire logic [4:0] od_sel = {ctrl_ff[pafm_pkg::OD_BIT1], ctrl_ff[pafm_pkg::OD_BIT0], 3'h0};

  genvar g;
  generate
    for (g = 0; g < pafm_pkg::NPIN; g++) begin : g_pin
      pafm_pkg::pafm_pin_t drv;
      pafm_pin_cell u_cell (
        .dout_i(eff_dat[g]),
        .dir_out_i(eff_dir[g]),
        .od_sel_i(od_sel[g]),
        .pin_o(drv)
      );
      assign pin_out_o[g] = drv.out;
      assign pin_oe_n_o[g] = drv.oe_n;
    end
  endgenerate

  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  wire logic aw_fire = s_axi_awvalid && s_axi_awready;
  wire logic w_fire = s_axi_wvalid && s_axi_wready;
  wire logic aw_have = aw_got_ff || aw_fire;
  wire logic w_have = w_got_ff || w_fire;
  wire logic [3:0] wr_ofs = aw_got_ff ? aw_ofs_ff : s_axi_awaddr[3:0];
  wire logic [31:0] wr_dat = w_got_ff ? wdata_ff : s_axi_wdata;
  wire logic [3:0] wr_stb = w_got_ff ? wstrb_ff : s_axi_wstrb;
  // The high-address check travels with a captured address, so a late data beat cannot hide it
  wire logic aw_hi_bad_now = s_axi_awaddr[31:4] != 28'h0;
  wire logic wr_hi_bad = aw_got_ff ? aw_hi_bad_ff : aw_hi_bad_now;
  wire logic wr_go = aw_have && w_have && !bvalid_ff;
  wire logic wr_ctrl = wr_go && wr_ofs == pafm_pkg::CTRL_OFS;
  wire logic wr_port = wr_go && wr_ofs == pafm_pkg::PORT_OFS;
  wire logic wr_stat = wr_go && wr_ofs == pafm_pkg::STAT_OFS;
  wire logic [31:0] bmask = {{8{wr_stb[3]}}, {8{wr_stb[2]}}, {8{wr_stb[1]}}, {8{wr_stb[0]}}};
  wire logic wr_map_ok = (wr_ctrl || wr_port || wr_stat) && !wr_hi_bad;
  wire logic [31:0] nxt_ctrl = ((ctrl_ff & ~bmask) | (wr_dat & bmask)) & pafm_pkg::CTRL_WMASK;
  wire logic [31:0] nxt_port = ((port_ff & ~bmask) | (wr_dat & bmask)) & pafm_pkg::PORT_WMASK;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_ofs_ff <= 4'h0;
      aw_hi_bad_ff <= 1'b0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= pafm_pkg::RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_map_ok ? pafm_pkg::RESP_OKAY : pafm_pkg::RESP_SLVERR;
      end else begin
        if (aw_fire) begin
          aw_got_ff <= 1'b1;
          aw_ofs_ff <= s_axi_awaddr[3:0];
          aw_hi_bad_ff <= aw_hi_bad_now;
        end
        if (w_fire) begin
          w_got_ff <= 1'b1;
          wdata_ff <= s_axi_wdata;
          wstrb_ff <= s_axi_wstrb;
        end
        if (bvalid_ff && s_axi_bready) begin
          bvalid_ff <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ctrl_ff <= pafm_pkg::CTRL_RST;
      port_ff <= pafm_pkg::PORT_RST;
    end else begin
      if (wr_ctrl && !wr_hi_bad) begin
        ctrl_ff <= nxt_ctrl;
      end
      if (wr_port && !wr_hi_bad) begin
        port_ff <= nxt_port;
      end
    end
  end

  // Read path; status shows synchronised pin levels and the effective drive
  assign s_axi_arready = !rvalid_ff;
  wire logic ar_fire = s_axi_arvalid && s_axi_arready;
  wire logic [31:0] stat_val = {11'h0, eff_dir, 3'h0, alt_sel, 3'h0, sync2_ff};
  wire logic rd_hit = s_axi_araddr[31:4] == 28'h0;
  logic [31:0] rd_val;
  logic rd_ok;
  wire logic rd_ofs_ctrl = s_axi_araddr[3:0] == pafm_pkg::CTRL_OFS;
  wire logic rd_ofs_port = s_axi_araddr[3:0] == pafm_pkg::PORT_OFS;
  wire logic rd_ofs_stat = s_axi_araddr[3:0] == pafm_pkg::STAT_OFS;
  // Unmapped reads return zero with an error response
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b0;
    if (!rd_hit) begin
      rd_ok = 1'b0;
    end else if (rd_ofs_ctrl) begin
      rd_val = ctrl_ff;
      rd_ok = 1'b1;
    end else if (rd_ofs_port) begin
      rd_val = port_ff;
      rd_ok = 1'b1;
    end else if (rd_ofs_stat) begin
      rd_val = stat_val;
      rd_ok = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= pafm_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_val;
      rresp_ff <= rd_ok ? pafm_pkg::RESP_OKAY : pafm_pkg::RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
endmodule : pafm_mux

// ### pafm_checker.sv
// Checker for pafm_mux: bus answer timing and pin input timing.
// Assumes it is bound to every pafm_mux and sees only its ports.
`timescale 1ns/100ps
module pafm_checker (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [4:0] pin_in_i,
  input wire logic [4:0] pin_oe_n_o,
  input wire logic bus_ready_o,
  input wire logic serial_receive_input_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_wr_answer: assert property (wr_taken |=> s_axi_bvalid)
    else $error("write not answered");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while busy");
  a_rx_synced: assert property (!serial_receive_input_o |-> !$past(pin_in_i[3], 2))
    else $error("receive level without cause");
  a_rdy_synced: assert property (!bus_ready_o |-> !$past(pin_in_i[1], 2))
    else $error("ready low without cause");
  // Reset itself is the cause here, so this one is never disabled
  a_reset_idle: assert property (disable iff (1'b0) !resetn_i |=> pin_oe_n_o == 5'h1f && !s_axi_bvalid)
    else $error("pins driven after reset");
endmodule : pafm_checker
bind pafm_mux pafm_checker pafm_checker_inst (.ref_clk_i, .resetn_i, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pin_in_i, .pin_oe_n_o, .bus_ready_o, .serial_receive_input_o);

// ### pafm_far_side.sv
// Far side of the five port pins: board pull-ups and external drivers.
// Assumes all parties share each wire, so levels wire-AND together.
`timescale 1ns/100ps
module pafm_far_side (
  input wire logic [4:0] pin_out_i,
  input wire logic [4:0] pin_oe_n_i,
  input wire logic [4:0] ext_low_i,
  output logic [4:0] pin_lvl_o
);
  // A released pin rises through its pull-up; any low driver wins
  assign pin_lvl_o = (pin_out_i | pin_oe_n_i) & ~ext_low_i;
endmodule : pafm_far_side

// ### pafm_mux_tb_top.sv
// Testbench for pafm_mux: register writes over AXI4-Lite, then pin checks.
// Assumes pulled-up pins that the far side may pull low.
`timescale 1ns/100ps
module pafm_mux_tb_top;
  localparam logic [31:0] C = 32'(pafm_pkg::CTRL_OFS);
  localparam logic [31:0] P = 32'(pafm_pkg::PORT_OFS);
  localparam logic [1:0] OK = pafm_pkg::RESP_OKAY;
  logic ref_clk_i = 1'h0, resetn_i = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, machine_clk_i = 1'h0;
  logic hold_acknowledge_out_i = 1'h0, serial_transmit_output_i = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_ready_o, serial_receive_input_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] ext_low = 5'h0, pin_in_i, pin_out_o, pin_oe_n_o;
  int failures = 0, cmp_count = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  pafm_mux pafm_mux_inst (.ref_clk_i, .resetn_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .machine_clk_i,
    .hold_acknowledge_out_i, .serial_transmit_output_i, .bus_ready_o, .serial_receive_input_o, .pin_in_i,
    .pin_out_o, .pin_oe_n_o);
  pafm_far_side pafm_far_side_inst (.pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o), .ext_low_i(ext_low),
    .pin_lvl_o(pin_in_i));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  // Handshakes are judged at the falling edge so the rising edge stays race free
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge ref_clk_i);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    forever begin
      @(negedge ref_clk_i);
      {ta, tw, tb, r} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bready & s_axi_bvalid, s_axi_bresp};
      @(posedge ref_clk_i);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) begin
        s_axi_bready <= 1'h0;
        cmp("bresp", 32'(er), 32'(r));
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [33:0] v;
    @(posedge ref_clk_i);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    forever begin
      @(negedge ref_clk_i);
      {ta, tr, v} = {s_axi_arvalid & s_axi_arready, s_axi_rready & s_axi_rvalid, s_axi_rresp, s_axi_rdata};
      @(posedge ref_clk_i);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) begin
        s_axi_rready <= 1'h0;
        cmp("rresp", 32'(er), 32'(v[33:32]));
        cmp("rdata", ed, v[31:0]);
        break;
      end
    end
  endtask : rd
  task automatic pins(input logic [4:0] eo, input logic [4:0] en);
    repeat (3) @(negedge ref_clk_i);
    cmp("pin_oe_n", 32'(en), 32'(pin_oe_n_o));
    cmp("pin_out", 32'(eo & ~en), 32'(pin_out_o & ~pin_oe_n_o));
  endtask : pins
  task automatic conclude();
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  initial begin
    #100us;
    failures++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'h1;
    rd(C, pafm_pkg::CTRL_RST, OK);
    rd(P, pafm_pkg::PORT_RST, OK);
    pins(5'h00, 5'h1f);
    wr(P, 32'h1f15, OK);
    pins(5'h15, 5'h00);
    wr(C, 32'h300, OK);
    pins(5'h05, 5'h10);
    wr(P, 32'h0715, OK);
    pins(5'h05, 5'h18);
    wr(P, 32'h1f1f, OK);
    pins(5'h07, 5'h18);
    wr(C, 32'h210, OK);
    pins(5'h0f, 5'h00);
    @(posedge ref_clk_i) serial_transmit_output_i <= 1'h1;
    pins(5'h0f, 5'h10);
    wr(C, 32'h00e, OK);
    @(posedge ref_clk_i) ext_low <= 5'h02;
    pins(5'h1f, 5'h00);
    cmp("bus_ready", 32'h1, 32'(bus_ready_o));
    wr(C, 32'h00f, OK);
    pins(5'h18, 5'h02);
    cmp("bus_ready", 32'h0, 32'(bus_ready_o));
    @(posedge ref_clk_i) {machine_clk_i, hold_acknowledge_out_i, ext_low} <= 7'h60;
    pins(5'h1d, 5'h02);
    cmp("bus_ready", 32'h1, 32'(bus_ready_o));
    wr(C, 32'h020, OK);
    @(posedge ref_clk_i) ext_low <= 5'h08;
    pins(5'h1f, 5'h00);
    cmp("ser_rx", 32'h0, 32'(serial_receive_input_o));
    wr(32'hc, 32'h1, pafm_pkg::RESP_SLVERR);
    rd(32'hc, 32'h0, pafm_pkg::RESP_SLVERR);
    rd(C, 32'h020, OK);
    rd(32'h8, 32'h001f_0017, OK);
    @(posedge ref_clk_i) resetn_i <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'h1;
    rd(C, pafm_pkg::CTRL_RST, OK);
    rd(P, pafm_pkg::PORT_RST, OK);
    pins(5'h00, 5'h1f);
    conclude();
  end
endmodule : pafm_mux_tb_top
